// *** clock_gating_pkg.sv ***
// Purpose: Shared constants, types and helpers for the peripheral clock gating block.
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half of each word except the 32-bit clock run status.
// Notes:   Register indices are word indices; the byte address is four times the index.
package clock_gating_pkg;

  // Register word indices, decoded from awaddr/araddr bits [7:2]
  localparam logic [5:0] SERIAL_PWM_CLOCK_ENABLE_IDX = 6'h0c;
  localparam logic [5:0] TIMER_CLOCK_ENABLE_IDX      = 6'h0d;
  localparam logic [5:0] STOP_KEEPALIVE_CTRL0_IDX    = 6'h0e;
  localparam logic [5:0] CLOCK_RUN_STATUS_IDX        = 6'h14;
  localparam logic [5:0] POWER_MODE_STATUS_IDX       = 6'h15;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 16;

  // Implemented (writable) bits; all others are reserved and read as zero
  localparam logic [15:0] SERIAL_PWM_IMPL_MASK = 16'hf47d;
  localparam logic [15:0] TIMER_IMPL_MASK      = 16'h70ff;
  localparam logic [15:0] STOP_KEEP_IMPL_MASK  = 16'hf47d;
  localparam logic [15:0] REG_RESET            = 16'h0000;

  // Keep-alive groups in the stop keep-alive register
  localparam logic [15:0] ANALOG_KEEP_MASK        = 16'hf000;
  localparam logic [15:0] CONVERTER_TWO_WIRE_MASK = 16'h0440;
  localparam logic [15:0] SERIAL_MOD_KEEP_MASK    = 16'h003d;

  // Bit positions in the serial/modulator enable register
  localparam int unsigned MODULATOR_BIT      = 0;
  localparam int unsigned QUEUED_SERIAL_A_BIT = 2;
  localparam int unsigned QUEUED_SERIAL_B_BIT = 3;
  localparam int unsigned SERIAL_COMM_A_BIT  = 4;

  // Bit positions in the timer enable register
  localparam int unsigned INTERVAL_TIMER_LO  = 12;
  localparam int unsigned INTERVAL_TIMER_HI  = 14;
  localparam int unsigned TIMER_B_LO         = 4;
  localparam int unsigned TIMER_B_HI         = 7;
  localparam int unsigned TIMER_A_LO         = 0;
  localparam int unsigned TIMER_A_HI         = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    RUN_STATE  = 1'b0,
    STOP_STATE = 1'b1
  } power_state_type;

  typedef struct packed {
    power_state_type   pstate;
    logic              wake;
    logic [15:0]       serial_pwm_clock_enable;
    logic [15:0]       timer_clock_enable;
    logic [15:0]       stop_keepalive_ctrl0;
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } gating_state_type;

  // Byte-lane merge limited to the implemented bits of one register
  function automatic logic [15:0] merge_reg(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res & mask;
  endfunction

endpackage

// *** clock_gate_cell.sv ***
// Purpose: One peripheral clock enable, registered, with optional Stop-mode keep-alive.
// Assumes: Peripherals use run as a clock enable on clk_sys.
// Notes:   CAN_KEEP=0 for peripherals without a keep-alive bit in this block.
`timescale 1ns/100ps
module clock_gate_cell
  import clock_gating_pkg::*;
#(
  parameter bit CAN_KEEP = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic keep,
  input  wire logic stop_mode,
  // Gated enable
  output logic      run
);

  typedef struct packed {
    logic run;
  } cell_state_type;

  cell_state_type st;
  cell_state_type next_st;

  always_comb begin
    next_st     = st;
    // Enable alone never keeps a clock alive across Stop mode
    next_st.run = enable && (!stop_mode || (CAN_KEEP && keep));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign run = st.run;

endmodule // clock_gate_cell

// *** access_filter.sv ***
// Purpose: Passes peripheral register accesses only to peripherals whose clock runs.
// Assumes: acc_sel indexes the 32 gated enables, serial/modulator first, timers above.
// Notes:   A blocked access is dropped, so the peripheral state cannot change.
`timescale 1ns/100ps
module access_filter
  import clock_gating_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Access request
  input  wire logic        acc_valid,
  input  wire logic [4:0]  acc_sel,
  input  wire logic [31:0] running,
  // Result
  output logic             acc_fwd,
  output logic             acc_blocked
);

  typedef struct packed {
    logic fwd;
    logic blocked;
  } filter_state_type;

  filter_state_type st;
  filter_state_type next_st;

  always_comb begin
    next_st         = st;
    next_st.fwd     = acc_valid && running[acc_sel];
    next_st.blocked = acc_valid && !running[acc_sel];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign acc_fwd     = st.fwd;
  assign acc_blocked = st.blocked;

endmodule // access_filter

// *** peripheral_clock_gating.sv ***
// Purpose: Per-peripheral clock enables with Stop-mode keep-alive and wake-up, AXI4-Lite registers.
// Assumes: Peripherals run on clk_sys and use the gated outputs as clock enables.
// Notes:   Gated enables lag register writes and mode changes by one clock.
`timescale 1ns/100ps
module peripheral_clock_gating
  import clock_gating_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Power mode control from the core
  input  wire logic              stop_req,
  input  wire logic [31:0]       periph_irq,
  output logic                   stop_mode,
  output logic                   wake_pulse,
  // Peripheral access path
  input  wire logic              acc_valid,
  input  wire logic [4:0]        acc_sel,
  output logic                   acc_fwd,
  output logic                   acc_blocked,
  // Gated peripheral clock enables
  output logic [15:0]            serial_pwm_clk_run,
  output logic [15:0]            timer_clk_run
);

  gating_state_type st;
  gating_state_type next_st;
  logic [31:0]      running;

  localparam gating_state_type RESET_ST = '{
    pstate:                  RUN_STATE,
    wake:                    1'b0,
    serial_pwm_clock_enable: REG_RESET,
    timer_clock_enable:      REG_RESET,
    stop_keepalive_ctrl0:    REG_RESET,
    aw_held:                 1'b0,
    aw_addr:                 '0,
    w_held:                  1'b0,
    w_data:                  '0,
    w_strb:                  '0,
    awready:                 1'b1,
    wready:                  1'b1,
    bvalid:                  1'b0,
    bresp:                   RESP_OKAY,
    arready:                 1'b1,
    rvalid:                  1'b0,
    rdata:                   '0,
    rresp:                   RESP_OKAY
  };

  assign running = {timer_clk_run, serial_pwm_clk_run};

  always_comb begin
    next_st      = st;
    next_st.wake = 1'b0;

    // Address and data are captured independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Reserved bits are masked off, so a careless write cannot set them
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      unique case (st.aw_addr[7:2])
        SERIAL_PWM_CLOCK_ENABLE_IDX: begin
          next_st.serial_pwm_clock_enable = merge_reg(st.serial_pwm_clock_enable, st.w_data,
                                                      st.w_strb, SERIAL_PWM_IMPL_MASK);
        end
        TIMER_CLOCK_ENABLE_IDX: begin
          next_st.timer_clock_enable = merge_reg(st.timer_clock_enable, st.w_data,
                                                 st.w_strb, TIMER_IMPL_MASK);
        end
        STOP_KEEPALIVE_CTRL0_IDX: begin
          next_st.stop_keepalive_ctrl0 = merge_reg(st.stop_keepalive_ctrl0, st.w_data,
                                                   st.w_strb, STOP_KEEP_IMPL_MASK);
        end
        CLOCK_RUN_STATUS_IDX, POWER_MODE_STATUS_IDX: begin
          // Status words ignore writes
          next_st.bresp = RESP_OKAY;
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Hold off new writes while a response is outstanding
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        SERIAL_PWM_CLOCK_ENABLE_IDX: next_st.rdata = {16'h0000, st.serial_pwm_clock_enable};
        TIMER_CLOCK_ENABLE_IDX:      next_st.rdata = {16'h0000, st.timer_clock_enable};
        STOP_KEEPALIVE_CTRL0_IDX:    next_st.rdata = {16'h0000, st.stop_keepalive_ctrl0};
        CLOCK_RUN_STATUS_IDX:        next_st.rdata = running;
        POWER_MODE_STATUS_IDX:       next_st.rdata = {31'h0000_0000, st.pstate};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // Only a peripheral whose enable survived into Stop can raise a wake-up
    unique case (st.pstate)
      RUN_STATE: begin
        if (stop_req) begin
          next_st.pstate = STOP_STATE;
        end
      end
      STOP_STATE: begin
        if (|(periph_irq & running)) begin
          next_st.pstate = RUN_STATE;
          next_st.wake   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Serial, converter, comparator and modulator enables carry keep-alive bits
  for (genvar g = 0; g < REG_W; g++) begin : g_serial_pwm
    clock_gate_cell #(
      .CAN_KEEP (STOP_KEEP_IMPL_MASK[g])
    ) u_gate (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .enable    (st.serial_pwm_clock_enable[g]),
      .keep      (st.stop_keepalive_ctrl0[g]),
      .stop_mode (st.pstate),
      .run       (serial_pwm_clk_run[g])
    );
  end

  // Timer keep-alive bits live outside this block, so timers always stop in Stop mode
  for (genvar g = 0; g < REG_W; g++) begin : g_timer
    clock_gate_cell #(
      .CAN_KEEP (1'b0)
    ) u_gate (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .enable    (st.timer_clock_enable[g]),
      .keep      (1'b0),
      .stop_mode (st.pstate),
      .run       (timer_clk_run[g])
    );
  end

  access_filter u_access_filter (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .acc_valid   (acc_valid),
    .acc_sel     (acc_sel),
    .running     (running),
    .acc_fwd     (acc_fwd),
    .acc_blocked (acc_blocked)
  );

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign stop_mode     = st.pstate;
  assign wake_pulse    = st.wake;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_serial_comm_a;
    st.serial_pwm_clock_enable[SERIAL_COMM_A_BIT] && !stop_mode |=> serial_pwm_clk_run[SERIAL_COMM_A_BIT];
  endproperty
  a_serial_comm_a: assert property (p_serial_comm_a) else $error("serial comm a clock missing");

  property p_queued_b;
    !st.serial_pwm_clock_enable[QUEUED_SERIAL_B_BIT] |=> !serial_pwm_clk_run[QUEUED_SERIAL_B_BIT];
  endproperty
  a_queued_b: assert property (p_queued_b) else $error("queued serial b clock not removed");

  property p_queued_a;
    st.serial_pwm_clock_enable[QUEUED_SERIAL_A_BIT] && !stop_mode |=> serial_pwm_clk_run[QUEUED_SERIAL_A_BIT];
  endproperty
  a_queued_a: assert property (p_queued_a) else $error("queued serial a clock missing");

  property p_modulator;
    !st.serial_pwm_clock_enable[MODULATOR_BIT] |=> !serial_pwm_clk_run[MODULATOR_BIT];
  endproperty
  a_modulator: assert property (p_modulator) else $error("modulator clock not removed");

  property p_interval;
    !stop_mode |=> timer_clk_run[INTERVAL_TIMER_HI:INTERVAL_TIMER_LO]
                   == $past(st.timer_clock_enable[INTERVAL_TIMER_HI:INTERVAL_TIMER_LO]);
  endproperty
  a_interval: assert property (p_interval) else $error("interval timer clocks wrong");

  property p_timer_b;
    !stop_mode |=> timer_clk_run[TIMER_B_HI:TIMER_B_LO] == $past(st.timer_clock_enable[TIMER_B_HI:TIMER_B_LO]);
  endproperty
  a_timer_b: assert property (p_timer_b) else $error("timer b channel clocks wrong");

  property p_timer_a;
    !stop_mode |=> timer_clk_run[TIMER_A_HI:TIMER_A_LO] == $past(st.timer_clock_enable[TIMER_A_HI:TIMER_A_LO]);
  endproperty
  a_timer_a: assert property (p_timer_a) else $error("timer a channel clocks wrong");

  property p_stop_all;
    stop_mode |=> timer_clk_run == 16'h0000;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("timer clock runs in stop mode");

  property p_keep;
    stop_mode |=> serial_pwm_clk_run
                  == $past(st.serial_pwm_clock_enable & st.stop_keepalive_ctrl0 & STOP_KEEP_IMPL_MASK);
  endproperty
  a_keep: assert property (p_keep) else $error("stop keep-alive mismatch");

  property p_keep_analog;
    stop_mode |=> (serial_pwm_clk_run & ANALOG_KEEP_MASK)
                  == ($past(st.serial_pwm_clock_enable & st.stop_keepalive_ctrl0) & ANALOG_KEEP_MASK);
  endproperty
  a_keep_analog: assert property (p_keep_analog) else $error("comparator or dac keep-alive wrong");

  property p_keep_converter;
    stop_mode |=> (serial_pwm_clk_run & CONVERTER_TWO_WIRE_MASK)
                  == ($past(st.serial_pwm_clock_enable & st.stop_keepalive_ctrl0) & CONVERTER_TWO_WIRE_MASK);
  endproperty
  a_keep_converter: assert property (p_keep_converter) else $error("converter or two-wire keep-alive wrong");

  property p_keep_serial;
    stop_mode |=> (serial_pwm_clk_run & SERIAL_MOD_KEEP_MASK)
                  == ($past(st.serial_pwm_clock_enable & st.stop_keepalive_ctrl0) & SERIAL_MOD_KEEP_MASK);
  endproperty
  a_keep_serial: assert property (p_keep_serial) else $error("serial or modulator keep-alive wrong");

  // A cleared enable silences its output whatever the keep bit says
  property p_disabled_held;
    1'b1 |=> ((serial_pwm_clk_run & ~$past(st.serial_pwm_clock_enable)) == '0)
             && ((timer_clk_run & ~$past(st.timer_clock_enable)) == '0);
  endproperty
  a_disabled_held: assert property (p_disabled_held) else $error("disabled peripheral clock runs");

  // Checked while reset is low, so the default disable is overridden here
  property p_reset_clear;
    disable iff (1'b0)
    !rst_n |=> st.serial_pwm_clock_enable == REG_RESET && st.timer_clock_enable == REG_RESET
               && st.stop_keepalive_ctrl0 == REG_RESET && !stop_mode
               && serial_pwm_clk_run == '0 && timer_clk_run == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left a clock bit set");

  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("new write taken during response");

  property p_one_read;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_one_read: assert property (p_one_read) else $error("new read taken during response");

  property p_wake;
    stop_mode && |(periph_irq & running) |=> !stop_mode && wake_pulse ##1 !wake_pulse;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up not taken");

  property p_access;
    acc_valid && !running[acc_sel] |=> !acc_fwd && acc_blocked;
  endproperty
  a_access: assert property (p_access) else $error("access to unclocked peripheral passed");

  c_write: cover property (st.bvalid && s_axi_bready && st.bresp == RESP_OKAY);
  c_read: cover property (st.rvalid && s_axi_rready);
  c_wake: cover property (wake_pulse);
  c_blocked: cover property (acc_blocked);
  c_stop_keep: cover property (stop_mode && |serial_pwm_clk_run);

endmodule // peripheral_clock_gating

// *** peripheral_side_model.sv ***
// Purpose: Stand-in for the peripherals that receive the gated clock enables.
// Assumes: Peripheral index matches {timer_clk_run, serial_pwm_clk_run}.
// Notes:   irq_raw lets a scenario fire an interrupt from an unclocked peripheral.
`timescale 1ns/100ps
module peripheral_side_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Gated enables from the block
  input  wire logic [15:0] serial_pwm_clk_run,
  input  wire logic [15:0] timer_clk_run,
  // Bench commands
  input  wire logic [4:0]  irq_sel,
  input  wire logic        irq_go,
  input  wire logic        irq_raw,
  // Interrupt levels
  output logic      [31:0] periph_irq
);
  logic [31:0] running;

  assign running = {timer_clk_run, serial_pwm_clk_run};

  // A peripheral without its clock raises an interrupt only when irq_raw is set
  always_ff @(posedge clk_sys) begin
    periph_irq <= 32'h0000_0000;
    if (rst_n && irq_go && (irq_raw || running[irq_sel])) begin
      periph_irq[irq_sel] <= 1'b1;
    end
  end
endmodule // peripheral_side_model

// *** peripheral_clock_gating_bench.sv ***
// Purpose: Self-checking bench for the peripheral clock gating block.
// Assumes: AXI4-Lite register access, single clock.
// Notes:   Ready and answer signals are sampled at the falling edge before the taking edge.
`timescale 1ns/100ps
module peripheral_clock_gating_bench;
  import clock_gating_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        stop_req = 1'b0;
  logic        acc_valid = 1'b0;
  logic [4:0]  acc_sel = 5'h00;
  logic [4:0]  irq_sel = 5'h00;
  logic        irq_go = 1'b0;
  logic        irq_raw = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        stop_mode, wake_pulse, acc_fwd, acc_blocked;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, periph_irq, v;
  logic [15:0] sp_run, tm_run;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  peripheral_clock_gating i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_req(stop_req), .periph_irq(periph_irq), .stop_mode(stop_mode), .wake_pulse(wake_pulse),
    .acc_valid(acc_valid), .acc_sel(acc_sel), .acc_fwd(acc_fwd), .acc_blocked(acc_blocked),
    .serial_pwm_clk_run(sp_run), .timer_clk_run(tm_run)
  );

  peripheral_side_model i_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_pwm_clk_run(sp_run), .timer_clk_run(tm_run),
    .irq_sel(irq_sel), .irq_go(irq_go), .irq_raw(irq_raw), .periph_irq(periph_irq)
  );

  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang costs one mismatch and closes the run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, s1, s2;
    logic [1:0] r;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys);
      s1 = awready;
      s2 = wready;
      @(posedge clk_sys);
      if (s1 === 1'b1 && !aw_ok) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (s2 === 1'b1 && !w_ok) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    s1 = 1'b0;
    while (s1 !== 1'b1) begin
      @(negedge clk_sys);
      s1 = bvalid;
      r = bresp;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic s;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    s = 1'b0;
    while (s !== 1'b1) begin @(negedge clk_sys); s = arready; @(posedge clk_sys); end
    arvalid <= 1'b0;
    s = 1'b0;
    while (s !== 1'b1) begin @(negedge clk_sys); s = rvalid; d = rdata; r = rresp; @(posedge clk_sys); end
    rready <= 1'b0;
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  task automatic acc(input logic [4:0] s, input logic f);
    @(posedge clk_sys);
    acc_valid <= 1'b1; acc_sel <= s;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
    @(negedge clk_sys);
    chk(32'(acc_fwd), 32'(f));
    chk(32'(acc_blocked), 32'(!f));
  endtask

  task automatic irq(input logic [4:0] s, input logic raw, input int exp_wake);
    int seen;
    seen = 0;
    @(posedge clk_sys);
    irq_sel <= s; irq_raw <= raw; irq_go <= 1'b1;
    @(posedge clk_sys);
    irq_go <= 1'b0;
    repeat (5) begin @(negedge clk_sys); if (wake_pulse === 1'b1) seen++; end
    chk(32'(seen), 32'(exp_wake));
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk({tm_run, sp_run}, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000, RESP_OKAY);
    rd(8'h34, 32'h0000_0000, RESP_OKAY);
    rd(8'h38, 32'h0000_0000, RESP_OKAY);
    // Reserved bits are always written as zero
    wr(8'h30, 32'h0000_f47d, RESP_OKAY);
    wr(8'h34, 32'h0000_70ff, RESP_OKAY);
    wr(8'h38, 32'h0000_f47d, RESP_OKAY);
    cyc(1);
    chk({tm_run, sp_run}, 32'h70ff_f47d);
    rd(8'h30, 32'h0000_f47d, RESP_OKAY);
    rd(8'h34, 32'h0000_70ff, RESP_OKAY);
    rd(8'h38, 32'h0000_f47d, RESP_OKAY);
    rd(8'h50, 32'h70ff_f47d, RESP_OKAY);
    // Low lane only: the upper byte must survive
    wstrb <= 4'h1;
    wr(8'h30, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hf;
    rd(8'h30, 32'h0000_f400, RESP_OKAY);
    wr(8'h3c, 32'h0000_ffff, RESP_SLVERR);
    rd(8'h3c, 32'h0000_0000, RESP_SLVERR);
    // Walk a single one through both enable registers
    for (int i = 0; i < 16; i++) begin
      v = 32'h0000_0001 << i;
      wr(8'h30, v & 32'h0000_f47d, RESP_OKAY);
      wr(8'h34, v & 32'h0000_70ff, RESP_OKAY);
      cyc(1);
      chk(32'(sp_run), v & 32'h0000_f47d);
      chk(32'(tm_run), v & 32'h0000_70ff);
    end
    wr(8'h30, 32'h0000_0015, RESP_OKAY);
    wr(8'h34, 32'h0000_00ff, RESP_OKAY);
    wr(8'h38, 32'h0000_000d, RESP_OKAY);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    cyc(2);
    chk(32'(stop_mode), 32'h0000_0001);
    chk(32'(sp_run), 32'h0000_0005);
    chk(32'(tm_run), 32'h0000_0000);
    rd(8'h54, 32'h0000_0001, RESP_OKAY);
    acc(5'd4, 1'b0);
    acc(5'd2, 1'b1);
    acc(5'd16, 1'b0);
    // An unclocked peripheral must not end Stop
    irq(5'd4, 1'b1, 0);
    chk(32'(stop_mode), 32'h0000_0001);
    irq(5'd2, 1'b0, 1);
    chk(32'(stop_mode), 32'h0000_0000);
    chk({tm_run, sp_run}, 32'h00ff_0015);
    acc(5'd17, 1'b1);
    acc(5'd24, 1'b0);
    // Every keep-alive group of the serial register through one Stop
    wr(8'h30, 32'h0000_f47d, RESP_OKAY);
    wr(8'h38, 32'h0000_f470, RESP_OKAY);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    cyc(2);
    chk(32'(sp_run), 32'h0000_f470);
    chk(32'(tm_run), 32'h0000_0000);
    irq(5'd12, 1'b0, 1);
    chk(32'(stop_mode), 32'h0000_0000);
    end_sim();
  end
endmodule // peripheral_clock_gating_bench
